// ===== nv_register_interface.sv
// register interface to the internal nonvolatile data store
//
// Contract
// - the store holds 2048 bytes that survive loss of power.
// - the store is not in data space and is reached only via its registers.
// - byte mode moves one byte through the data register at the set address.
// - low address, high address and data registers sit in sector 0, direct.
// - the control register sits in sector 1 and is reached only indirectly.
// - the low address register holds address bits 7..0 and resets to zero.
// - the high address register holds bits 10..8; bits 7..3 read as zero.
// - the data register is an 8-bit read/write byte that resets to zero.
// - time select picks 3.2/2.2 ms or 3.7/3.0 ms for erase/write.
// - erase go starts an erase only with erase allow set; both clear at end.
// - write go starts a write only with write allow set; both clear at end.
// - the mode bit picks byte or 16-byte page operation via a page buffer.
`include "nv_consts.svh"

module nv_register_interface #(
	parameter int AW            = 11,
	parameter int DEPTH         = 2048,
	parameter int CW            = 16,
	parameter int ERASE_STD_CYC = `NV_T_ERASE_STD_US * `NV_CLK_MHZ,
	parameter int STORE_STD_CYC = `NV_T_STORE_STD_US * `NV_CLK_MHZ,
	parameter int ERASE_EXT_CYC = `NV_T_ERASE_EXT_US * `NV_CLK_MHZ,
	parameter int STORE_EXT_CYC = `NV_T_STORE_EXT_US * `NV_CLK_MHZ
)(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       sector_i,
	input  wire logic [7:0] addr_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	output logic            busy_o
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (AW != 11 || DEPTH != 2048)
	begin : g_bad_size
		$error("register layout serves exactly 2048 bytes");
	end

	localparam int PB = `NV_PAGE_BYTES;

	// the page step counter is four bits wide
	if (PB != 16)
	begin : g_bad_page
		$error("page buffer must hold sixteen bytes");
	end

	nv_store_if #(.AW(AW)) sif ();

	// ------------------------------------------------------------
	// storage and timer
	// ------------------------------------------------------------
	nv_store_array #(
		.AW    (AW),
		.DEPTH (DEPTH)
	) u_array (
		.clk_i (clk_i),
		.bus   (sif.mem)
	);

	nv_cycle_timer #(
		.CW            (CW),
		.ERASE_STD_CYC (ERASE_STD_CYC),
		.STORE_STD_CYC (STORE_STD_CYC),
		.ERASE_EXT_CYC (ERASE_EXT_CYC),
		.STORE_EXT_CYC (STORE_EXT_CYC)
	) u_timer (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bus   (sif.timer)
	);

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]           addr_low_reg;
	logic [2:0]           addr_high_reg;
	logic [7:0]           data_byte_reg;
	logic [7:0]           control_reg;
	logic [7:0]           rdata_reg;
	logic [7:0]           page_buf [PB];
	logic [3:0]           step_reg;
	logic                 erase_op_reg;
	logic                 page_op_reg;
	nv_pkg::seq_state_t   state_reg;
	nv_pkg::seq_state_t   state_next;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire sel_low  = sector_i == `NV_SEC_DIRECT &&
		addr_i == `NV_OFS_ADDR_LOW;
	wire sel_high = sector_i == `NV_SEC_DIRECT &&
		addr_i == `NV_OFS_ADDR_HIGH;
	wire sel_data = sector_i == `NV_SEC_DIRECT &&
		addr_i == `NV_OFS_DATA_BYTE;
	wire sel_ctrl = sector_i == `NV_SEC_INDIRECT &&
		addr_i == `NV_OFS_CONTROL;

	// control writes land only while idle, so a hardware clear at the end
	// of a cycle never meets a software write in the same clock
	wire idle      = state_reg == nv_pkg::ST_IDLE;
	wire ctrl_wr   = wr_i && sel_ctrl && idle;
	wire [AW-1:0] byte_addr = {addr_high_reg, addr_low_reg};
	wire [3:0]    col       = addr_low_reg[3:0];

	// triggers take only with the allow bit already held; erase first
	wire go_clear = ctrl_wr && wdata_i[`NV_B_CLEAR_GO] &&
		control_reg[`NV_B_CLEAR_ALLOW];
	wire go_store = ctrl_wr && wdata_i[`NV_B_STORE_GO] &&
		control_reg[`NV_B_STORE_ALLOW] && !go_clear;
	wire go_fetch = ctrl_wr && wdata_i[`NV_B_FETCH_GO] &&
		control_reg[`NV_B_FETCH_ALLOW] && !go_clear && !go_store;
	wire page_sel = wdata_i[`NV_B_PAGE_MODE];

	// read mux; unmapped addresses read zero
	wire [7:0] read_mux =
		sel_low  ? addr_low_reg :
		sel_high ? {5'h00, addr_high_reg} :
		sel_data ? data_byte_reg :
		sel_ctrl ? control_reg : 8'h00;

	// ------------------------------------------------------------
	// store port: program, erase or fetch address and data
	// ------------------------------------------------------------
	wire [AW-1:0] page_addr = {byte_addr[AW-1:4], step_reg};
	wire prog_st  = state_reg == nv_pkg::ST_PROGRAM;
	wire fetch_st = state_reg == nv_pkg::ST_FETCH_ADDR ||
		state_reg == nv_pkg::ST_FETCH_CAP;

	assign sif.mem_we    = prog_st;
	assign sif.mem_addr  = (page_op_reg && (prog_st || fetch_st))
		? page_addr : byte_addr;
	assign sif.mem_wdata = erase_op_reg ? `NV_ERASED_BYTE
		: (page_op_reg ? page_buf[step_reg] : data_byte_reg);
	assign sif.tmr_start = prog_st && (!page_op_reg || step_reg == 4'hF);
	assign sif.tmr_long  = control_reg[`NV_B_TIME_SEL];
	assign sif.tmr_erase = erase_op_reg;

	wire last_step = !page_op_reg || step_reg == 4'hF;

	// ------------------------------------------------------------
	// sequencer next state
	// ------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			nv_pkg::ST_IDLE:
				if (go_clear || go_store)
					state_next = nv_pkg::ST_PROGRAM;
				else if (go_fetch)
					state_next = nv_pkg::ST_FETCH_ADDR;
			nv_pkg::ST_PROGRAM:
				if (last_step)
					state_next = nv_pkg::ST_WAIT;
			nv_pkg::ST_WAIT:
				if (sif.tmr_done)
					state_next = nv_pkg::ST_IDLE;
			nv_pkg::ST_FETCH_ADDR:
				state_next = nv_pkg::ST_FETCH_CAP;
			nv_pkg::ST_FETCH_CAP:
				state_next = last_step ? nv_pkg::ST_IDLE
					: nv_pkg::ST_FETCH_ADDR;
			default:
				state_next = nv_pkg::ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// sequencer registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg    <= nv_pkg::ST_IDLE;
			step_reg     <= 4'h0;
			erase_op_reg <= 1'b0;
			page_op_reg  <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			// operation kind and page mode are frozen for the whole run
			if (idle)
			begin
				step_reg     <= 4'h0;
				erase_op_reg <= go_clear;
				page_op_reg  <= page_sel;
			end
			else if ((prog_st || state_reg == nv_pkg::ST_FETCH_CAP) &&
				!last_step)
				step_reg <= step_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// address registers, direct access only
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			addr_low_reg  <= `NV_RST_BYTE;
			addr_high_reg <= 3'h0;
		end
		else
		begin
			if (wr_i && sel_low)
				addr_low_reg <= wdata_i;
			if (wr_i && sel_high)
				addr_high_reg <= wdata_i[2:0];
		end
	end

	// ------------------------------------------------------------
	// data register: software writes, fetch results
	// ------------------------------------------------------------
	wire fetch_cap = state_reg == nv_pkg::ST_FETCH_CAP;
	wire cap_here  = fetch_cap && (!page_op_reg || step_reg == col);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			data_byte_reg <= `NV_RST_BYTE;
		else if (cap_here)
			data_byte_reg <= sif.mem_rdata;
		else if (wr_i && sel_data)
			data_byte_reg <= wdata_i;
	end

	// ------------------------------------------------------------
	// page buffer: filled by data writes in page mode or page fetch
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (fetch_cap && page_op_reg)
			page_buf[step_reg] <= sif.mem_rdata;
		else if (wr_i && sel_data && control_reg[`NV_B_PAGE_MODE] && idle)
			page_buf[col] <= wdata_i;
	end

	// ------------------------------------------------------------
	// control register: writes while idle, hardware clears at end
	// ------------------------------------------------------------
	wire end_cycle = state_reg == nv_pkg::ST_WAIT && sif.tmr_done;
	wire end_fetch = fetch_cap && last_step;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			control_reg <= `NV_RST_BYTE;
		else if (ctrl_wr)
		begin
			control_reg <= wdata_i;
			control_reg[`NV_B_CLEAR_GO] <= go_clear;
			control_reg[`NV_B_STORE_GO] <= go_store;
			control_reg[`NV_B_FETCH_GO] <= go_fetch;
		end
		else if (end_cycle && erase_op_reg)
		begin
			control_reg[`NV_B_CLEAR_GO]    <= 1'b0;
			control_reg[`NV_B_CLEAR_ALLOW] <= 1'b0;
		end
		else if (end_cycle)
		begin
			control_reg[`NV_B_STORE_GO]    <= 1'b0;
			control_reg[`NV_B_STORE_ALLOW] <= 1'b0;
		end
		else if (end_fetch)
			control_reg[`NV_B_FETCH_GO] <= 1'b0;
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rdata_reg <= 8'h00;
			busy_o    <= 1'b0;
		end
		else
		begin
			if (rd_i)
				rdata_reg <= read_mux;
			busy_o <= state_next != nv_pkg::ST_IDLE;
		end
	end

	assign rdata_o = rdata_reg;
endmodule : nv_register_interface

// ===== nv_consts.svh
// constants for the nonvolatile store register interface
`ifndef NV_CONSTS_SVH
`define NV_CONSTS_SVH

// ----------------------------------------------------------------
// register placement
// ----------------------------------------------------------------
`define NV_SEC_DIRECT     1'h0
`define NV_SEC_INDIRECT   1'h1
`define NV_OFS_ADDR_LOW   8'h2C
`define NV_OFS_ADDR_HIGH  8'h2D
`define NV_OFS_DATA_BYTE  8'h2E
`define NV_OFS_CONTROL    8'h40

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define NV_B_TIME_SEL     7
`define NV_B_CLEAR_ALLOW  6
`define NV_B_CLEAR_GO     5
`define NV_B_PAGE_MODE    4
`define NV_B_STORE_ALLOW  3
`define NV_B_STORE_GO     2
`define NV_B_FETCH_ALLOW  1
`define NV_B_FETCH_GO     0

// ----------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------
`define NV_RST_BYTE       8'h00
`define NV_ERASED_BYTE    8'hFF
`define NV_HIGH_MASK      8'h07
`define NV_PAGE_BYTES     16

// ----------------------------------------------------------------
// timing, in microseconds, and clock rate in MHz
// ----------------------------------------------------------------
`define NV_T_ERASE_STD_US 3200
`define NV_T_STORE_STD_US 2200
`define NV_T_ERASE_EXT_US 3700
`define NV_T_STORE_EXT_US 3000
`define NV_CLK_MHZ        10

`endif

// ===== nv_pkg.sv
// types shared by the nonvolatile store register interface
package nv_pkg;

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_PROGRAM,
		ST_WAIT,
		ST_FETCH_ADDR,
		ST_FETCH_CAP
	} seq_state_t;

endpackage : nv_pkg

// ===== nv_store_if.sv
// carrier between sequencer, storage array and cycle timer
interface nv_store_if #(
	parameter int AW = 11
);
	logic          mem_we;
	logic [AW-1:0] mem_addr;
	logic [7:0]    mem_wdata;
	logic [7:0]    mem_rdata;
	logic          tmr_start;
	logic          tmr_long;
	logic          tmr_erase;
	logic          tmr_done;

	modport ctrl (
		output mem_we, mem_addr, mem_wdata, tmr_start, tmr_long, tmr_erase,
		input  mem_rdata, tmr_done
	);
	modport mem (
		input  mem_we, mem_addr, mem_wdata,
		output mem_rdata
	);
	modport timer (
		input  tmr_start, tmr_long, tmr_erase,
		output tmr_done
	);
endinterface : nv_store_if

// ===== nv_store_array.sv
// byte-wide storage array with synchronous read and write
module nv_store_array #(
	parameter int AW    = 11,
	parameter int DEPTH = 2048
)(
	input wire logic clk_i,
	nv_store_if.mem  bus
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (DEPTH != (1 << AW))
	begin : g_bad_depth
		$error("depth must equal two to the address width");
	end

	// contents are not reset: they survive a reset like the real cells
	logic [7:0] cells [DEPTH];
	logic [7:0] rdata_reg;

	// ------------------------------------------------------------
	// one access per cycle
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (bus.mem_we)
			cells[bus.mem_addr] <= bus.mem_wdata;
		rdata_reg <= cells[bus.mem_addr];
	end

	assign bus.mem_rdata = rdata_reg;
endmodule : nv_store_array

// ===== nv_cycle_timer.sv
// erase and write cycle duration counter
module nv_cycle_timer #(
	parameter int CW            = 16,
	parameter int ERASE_STD_CYC = 32000,
	parameter int STORE_STD_CYC = 22000,
	parameter int ERASE_EXT_CYC = 37000,
	parameter int STORE_EXT_CYC = 30000
)(
	input wire logic clk_i,
	input wire logic rst_i,
	nv_store_if.timer bus
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (ERASE_STD_CYC < 1 || STORE_STD_CYC < 1 || ERASE_EXT_CYC < 1 ||
		STORE_EXT_CYC < 1 || ERASE_STD_CYC >= (1 << CW) ||
		STORE_STD_CYC >= (1 << CW) || ERASE_EXT_CYC >= (1 << CW) ||
		STORE_EXT_CYC >= (1 << CW))
	begin : g_bad_count
		$error("cycle counts must be at least one and fit the counter");
	end

	logic [CW-1:0] cnt_reg;
	logic          run_reg;
	logic          done_reg;
	wire  [CW-1:0] load_val;

	// duration chosen by time select and operation kind
	assign load_val = bus.tmr_erase
		? (bus.tmr_long ? CW'(ERASE_EXT_CYC) : CW'(ERASE_STD_CYC))
		: (bus.tmr_long ? CW'(STORE_EXT_CYC) : CW'(STORE_STD_CYC));

	// ------------------------------------------------------------
	// count down, pulse done at the end
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_reg  <= '0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= run_reg && cnt_reg == CW'(1);
			if (bus.tmr_start)
			begin
				cnt_reg <= load_val;
				run_reg <= 1'b1;
			end
			else if (run_reg)
			begin
				cnt_reg <= cnt_reg - CW'(1);
				run_reg <= cnt_reg != CW'(1);
			end
		end
	end

	assign bus.tmr_done = done_reg;
endmodule : nv_cycle_timer

// ===== nv_register_checker.sv
// concurrent checks on the ports of the nonvolatile store register block
`include "nv_consts.svh"

module nv_register_checker #(
	parameter int STORE_STD_CYC = 22000,
	parameter int STORE_EXT_CYC = 30000,
	parameter int ERASE_STD_CYC = 32000
)(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       sector_i,
	input wire logic [7:0] addr_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic       busy_o
);
	// ------------------------------------------------------------
	// helper decode and last accepted control value
	// ------------------------------------------------------------
	localparam logic [15:0] SL = 16'(STORE_STD_CYC);
	localparam logic [15:0] SH = 16'(STORE_STD_CYC + 4);
	localparam logic [15:0] XL = 16'(STORE_EXT_CYC);
	localparam logic [15:0] XH = 16'(STORE_EXT_CYC + 4);
	localparam logic [15:0] EL = 16'(ERASE_STD_CYC);
	localparam logic [15:0] EH = 16'(ERASE_STD_CYC + 4);
	logic [7:0]  last_ctrl_reg;
	logic [15:0] busy_len_reg;
	wire        ctrl_sel = sector_i && addr_i == `NV_OFS_CONTROL;
	wire        ctrl_wr  = wr_i && ctrl_sel;
	wire        low_sel  = !sector_i && addr_i == `NV_OFS_ADDR_LOW;
	wire        mapped   = ctrl_sel || (!sector_i &&
		(addr_i == `NV_OFS_ADDR_LOW || addr_i == `NV_OFS_ADDR_HIGH ||
		addr_i == `NV_OFS_DATA_BYTE));

	// remember what software last wrote to control while idle
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			last_ctrl_reg <= 8'h00;
		else if (ctrl_wr && !busy_o)
			last_ctrl_reg <= wdata_i;

	// cycles that busy has stood high in the current run
	always_ff @(posedge clk_i or posedge rst_i)
		if (rst_i)
			busy_len_reg <= 16'h0000;
		else if (busy_o)
			busy_len_reg <= busy_len_reg + 16'h0001;
		else
			busy_len_reg <= 16'h0000;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// sequences and assertions
	// ------------------------------------------------------------
	sequence s_start(logic [7:0] v);
		$rose(busy_o) && last_ctrl_reg == v;
	endsequence
	sequence s_end(logic [7:0] v);
		$fell(busy_o) && last_ctrl_reg == v;
	endsequence
	sequence s_low_wr_rd;
		wr_i && low_sel ##1 !(wr_i && low_sel) ##1 rd_i && low_sel;
	endsequence

	chk_high_reads_zero: assert property (
		rd_i && !sector_i && addr_i == `NV_OFS_ADDR_HIGH
		|=> rdata_o[7:3] == 5'h00) else $error("high address top bits set");
	chk_unmapped_zero: assert property (
		rd_i && !mapped |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_low_echo: assert property (
		s_low_wr_rd |=> rdata_o == $past(wdata_i, 3))
		else $error("low address did not read back");
	chk_busy_cause: assert property (
		$rose(busy_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("busy rose without control write");
	chk_go_while_busy: assert property (
		rd_i && ctrl_sel && busy_o |=> rdata_o[`NV_B_CLEAR_GO] ||
		rdata_o[`NV_B_STORE_GO] || rdata_o[`NV_B_FETCH_GO])
		else $error("busy with no go bit set");
	chk_store_std_time: assert property (
		s_end(8'h0C) |-> busy_len_reg >= SL && busy_len_reg <= SH)
		else $error("standard write length wrong");
	chk_store_ext_time: assert property (
		s_end(8'h8C) |-> busy_len_reg >= XL && busy_len_reg <= XH)
		else $error("extended write length wrong");
	chk_erase_std_time: assert property (
		s_end(8'h60) |-> busy_len_reg >= EL && busy_len_reg <= EH)
		else $error("standard erase length wrong");
	chk_fetch_short: assert property (
		s_start(8'h03) |-> ##[1:4] !busy_o)
		else $error("byte read too long");
endmodule : nv_register_checker

bind nv_register_interface nv_register_checker #(
	.STORE_STD_CYC(STORE_STD_CYC),
	.STORE_EXT_CYC(STORE_EXT_CYC),
	.ERASE_STD_CYC(ERASE_STD_CYC)
) u_checker (.clk_i(clk_i), .rst_i(rst_i), .sector_i(sector_i),
	.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
	.rdata_o(rdata_o), .busy_o(busy_o));

// ===== testbench.sv
// self-checking bench for the nonvolatile store register interface
`include "nv_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// signals and control codes
	// ------------------------------------------------------------
	localparam logic [7:0] LO = `NV_OFS_ADDR_LOW;
	localparam logic [7:0] HI = `NV_OFS_ADDR_HIGH;
	localparam logic [7:0] DB = `NV_OFS_DATA_BYTE;
	localparam logic [7:0] CT = `NV_OFS_CONTROL;
	localparam logic [7:0] TS = 8'h01 << `NV_B_TIME_SEL;
	localparam logic [7:0] CA = 8'h01 << `NV_B_CLEAR_ALLOW;
	localparam logic [7:0] CG = 8'h01 << `NV_B_CLEAR_GO;
	localparam logic [7:0] PM = 8'h01 << `NV_B_PAGE_MODE;
	localparam logic [7:0] SA = 8'h01 << `NV_B_STORE_ALLOW;
	localparam logic [7:0] SG = 8'h01 << `NV_B_STORE_GO;
	localparam logic [7:0] FA = 8'h01 << `NV_B_FETCH_ALLOW;
	localparam logic [7:0] FG = 8'h01 << `NV_B_FETCH_GO;
	logic       clk_i, rst_i, sector_i, wr_i, rd_i, busy_o;
	logic [7:0] addr_i, wdata_i, rdata_o;
	int         failures, checks_done, n;

	nv_register_interface #(.ERASE_STD_CYC(20), .STORE_STD_CYC(10),
		.ERASE_EXT_CYC(25), .STORE_EXT_CYC(15)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .sector_i(sector_i),
		.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .busy_o(busy_o));

	// 100 ns clock
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// access tasks, driven from one falling edge to the next
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d);
		sector_i = s;
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
		@(negedge clk_i);
	endtask : wr

	task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
		sector_i = s;
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		check(rdata_o, e);
		@(negedge clk_i);
	endtask : rd

	task automatic set_addr(input logic [10:0] a);
		wr(1'b0, HI, {5'h00, a[10:8]});
		wr(1'b0, LO, a[7:0]);
	endtask : set_addr

	// allow first, then allow with go, as a second write
	task automatic ctl(input logic [7:0] allow, input logic [7:0] go);
		wr(1'b1, CT, allow);
		wr(1'b1, CT, allow | go);
	endtask : ctl

	task automatic wait_idle;
		n = 0;
		repeat (2) @(negedge clk_i);
		while (busy_o !== 1'b0)
		begin
			@(negedge clk_i);
			n++;
			if (n > 300)
			begin
				failures++;
				report_and_stop;
			end
		end
	endtask : wait_idle

	task automatic report_and_stop;
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_i = 1'b1;
		{sector_i, wr_i, rd_i, addr_i, wdata_i} = '0;
		failures = 0;
		checks_done = 0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		rd(1'b0, LO, 8'h00);
		rd(1'b0, HI, 8'h00);
		rd(1'b0, DB, 8'h00);
		rd(1'b1, CT, 8'h00);
		wr(1'b0, LO, 8'hA5);
		rd(1'b0, LO, 8'hA5);
		wr(1'b0, HI, 8'hFF);
		rd(1'b0, HI, 8'h07);
		wr(1'b0, DB, 8'h5A);
		rd(1'b0, DB, 8'h5A);
		rd(1'b0, CT, 8'h00);
		rd(1'b1, LO, 8'h00);
		// go bits with allow not already set are dropped
		wr(1'b1, CT, SA | SG);
		rd(1'b1, CT, SA);
		wr(1'b1, CT, CA | CG);
		rd(1'b1, CT, CA);
		wr(1'b1, CT, FG);
		rd(1'b1, CT, 8'h00);
		check({7'h00, busy_o}, 8'h00);
		// top location, then a control write refused while busy
		set_addr(11'h7FF);
		wr(1'b0, DB, 8'h3C);
		ctl(SA, SG);
		repeat (2) @(negedge clk_i);
		wr(1'b1, CT, FA);
		wait_idle;
		rd(1'b1, CT, 8'h00);
		set_addr(11'h0FF);
		wr(1'b0, DB, 8'hC3);
		ctl(SA, SG);
		wait_idle;
		set_addr(11'h7FF);
		ctl(FA, FG);
		wait_idle;
		rd(1'b0, DB, 8'h3C);
		rd(1'b1, CT, FA);
		// extended timing, go still visible mid-cycle
		wr(1'b0, DB, 8'h96);
		ctl(TS | SA, SG);
		repeat (2) @(negedge clk_i);
		rd(1'b1, CT, TS | SA | SG);
		wait_idle;
		rd(1'b1, CT, TS);
		ctl(FA, FG);
		wait_idle;
		rd(1'b0, DB, 8'h96);
		// erase leaves the erased pattern behind
		ctl(CA, CG);
		wait_idle;
		rd(1'b1, CT, 8'h00);
		ctl(FA, FG);
		wait_idle;
		rd(1'b0, DB, `NV_ERASED_BYTE);
		// page write through the page buffer
		set_addr(11'h010);
		wr(1'b1, CT, PM);
		for (int i = 0; i < `NV_PAGE_BYTES; i++)
		begin
			wr(1'b0, LO, 8'h10 + 8'(i));
			wr(1'b0, DB, 8'hA0 + 8'(i));
		end
		ctl(PM | SA, SG);
		wait_idle;
		wr(1'b0, LO, 8'h1B);
		ctl(FA, FG);
		wait_idle;
		rd(1'b0, DB, 8'hAB);
		// page read fills the buffer and hands back the addressed byte
		wr(1'b0, LO, 8'h15);
		ctl(PM | FA, FG);
		wait_idle;
		rd(1'b0, DB, 8'hA5);
		// a reset clears the registers but not the store
		rst_i = 1'b1;
		@(negedge clk_i);
		rst_i = 1'b0;
		rd(1'b0, LO, 8'h00);
		rd(1'b1, CT, 8'h00);
		set_addr(11'h0FF);
		ctl(FA, FG);
		wait_idle;
		rd(1'b0, DB, 8'hC3);
		report_and_stop;
	end
endmodule : testbench
